// >>> hw/fqw_host.sv
/*
 * Host controller for a quad serial flash: write enable, status read,
 * page program, dual and quad I/O reads and burst wrap setting.
 * Assumes one device in standard SPI mode 0, pins resolved outside
 * from out/enable pairs, and a user that polls busy itself.
 */
`timescale 1ns/1ps
module fqw_host (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic four_byte_mode,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fqw_pkg::fqw_cmd_t cmd,
    output logic cmd_refused,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic busy,
    output fqw_pkg::fqw_pins_t flash,
    input wire logic [3:0] io_in
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fqw_pkg::fqw_state_t st_reg, st_next, nxt_ph;
    fqw_pkg::fqw_cmd_t cmd_reg, cmd_next;
    logic [31:0] sh_reg, sh_next;
    logic [1:0] llog_reg, llog_next;
    logic [5:0] left_reg, left_next;
    logic [7:0] bytes_reg, bytes_next;
    logic [7:0] rx_reg, rx_next;
    logic [3:0] gap_reg, gap_next;
    logic rd_valid_reg, rd_valid_next;
    logic wel_reg, wel_next;
    logic need_reg, need_next;
    logic cs_n_reg, cs_n_next;
    logic refused_reg, refused_next;
    logic [3:0] io_out_reg, io_oe_reg;
    logic [3:0] io_s;
    logic sck, rise_p, fall_p;
    logic run;

    fqw_sync #(.W(4)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(io_in),
        .q(io_s)
    );

    fqw_sck_gen u_sck (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(run),
        .sck(sck),
        .rise_p(rise_p),
        .fall_p(fall_p)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire fqw_pkg::fqw_op_t op = cmd_reg.op;
    wire is_wrap = op == fqw_pkg::op_set_wrap;
    wire is_quad = op == fqw_pkg::op_quad_read ||
        op == fqw_pkg::op_quad_read4;
    wire is_dual = op == fqw_pkg::op_dual_read ||
        op == fqw_pkg::op_dual_read4;
    // Fixed 4-byte opcodes ignore the mode input
    wire four_b = four_byte_mode || op == fqw_pkg::op_dual_read4 ||
        op == fqw_pkg::op_quad_read4;
    wire [1:0] op_llog = (is_quad || is_wrap) ? 2'd2 :
        is_dual ? 2'd1 : 2'd0;
    wire [5:0] addr_clk = four_b ?
        6'(fqw_pkg::ADDR_BITS_4B >> op_llog) :
        6'(fqw_pkg::ADDR_BITS_3B >> op_llog);
    wire [5:0] mode_clk = 6'(fqw_pkg::MODE_BITS >> op_llog);
    // Wrap dummies go four lines wide
    wire [5:0] dummy_clk = !is_wrap ? 6'(fqw_pkg::QUAD_DUMMY_CLK) :
        four_b ? 6'(fqw_pkg::WRAP_DUMMY_CLK_4B) :
        6'(fqw_pkg::WRAP_DUMMY_CLK_3B);
    // Unused wrap bits sent as zero; dummies as ones to keep hold off
    wire [7:0] wrap_byte = 8'(cmd_reg.wrap_length_field)
        << fqw_pkg::WRAP_LEN_LSB |
        8'(cmd_reg.wrap_disable_bit) << fqw_pkg::WRAP_DIS_POS;
    wire [7:0] opcode =
        op == fqw_pkg::op_wren ? fqw_pkg::OPC_WREN :
        op == fqw_pkg::op_rdsr ? fqw_pkg::OPC_RDSR :
        op == fqw_pkg::op_program ? fqw_pkg::OPC_PROGRAM :
        op == fqw_pkg::op_dual_read ? fqw_pkg::OPC_DUAL_READ :
        op == fqw_pkg::op_dual_read4 ? fqw_pkg::OPC_DUAL_READ4 :
        op == fqw_pkg::op_quad_read ? fqw_pkg::OPC_QUAD_READ :
        op == fqw_pkg::op_quad_read4 ? fqw_pkg::OPC_QUAD_READ4 :
        fqw_pkg::OPC_SET_WRAP;
    wire [7:0] start_opc =
        cmd.op == fqw_pkg::op_wren ? fqw_pkg::OPC_WREN :
        cmd.op == fqw_pkg::op_rdsr ? fqw_pkg::OPC_RDSR :
        cmd.op == fqw_pkg::op_program ? fqw_pkg::OPC_PROGRAM :
        cmd.op == fqw_pkg::op_dual_read ? fqw_pkg::OPC_DUAL_READ :
        cmd.op == fqw_pkg::op_dual_read4 ? fqw_pkg::OPC_DUAL_READ4 :
        cmd.op == fqw_pkg::op_quad_read ? fqw_pkg::OPC_QUAD_READ :
        cmd.op == fqw_pkg::op_quad_read4 ? fqw_pkg::OPC_QUAD_READ4 :
        fqw_pkg::OPC_SET_WRAP;

    // Program without a preceding write enable is refused
    wire prog_blocked = cmd.op == fqw_pkg::op_program && !wel_reg;
    wire in_frame = st_reg != fqw_pkg::st_idle && st_reg != fqw_pkg::st_gap;
    assign run = in_frame && !need_reg;
    wire phase_end = fall_p && left_reg == 6'd1;
    wire tx = st_reg == fqw_pkg::st_cmd || st_reg == fqw_pkg::st_addr ||
        st_reg == fqw_pkg::st_mode || st_reg == fqw_pkg::st_wdata ||
        (st_reg == fqw_pkg::st_dummy && is_wrap);
    wire [3:0] lane_in = llog_reg == 2'd2 ? io_s :
        llog_reg == 2'd1 ? {2'b00, io_s[1:0]} : {3'b000, io_s[1]};
    wire [7:0] rx_shift = llog_reg == 2'd2 ? {rx_reg[3:0], lane_in} :
        llog_reg == 2'd1 ? {rx_reg[5:0], lane_in[1:0]} :
        {rx_reg[6:0], lane_in[0]};
    wire [3:0] io_out_next = llog_reg == 2'd2 ? sh_reg[31:28] :
        llog_reg == 2'd1 ? {2'b11, sh_reg[31:30]} :
        {3'b111, sh_reg[31]};
    wire [3:0] io_oe_next = !in_frame ? 4'h0 : {
        {2{tx || llog_reg != 2'd2}},
        tx && llog_reg != 2'd0,
        tx || llog_reg == 2'd0};

    always_comb begin
        unique case (st_reg)
            fqw_pkg::st_cmd: nxt_ph = op == fqw_pkg::op_wren ?
                fqw_pkg::st_gap : op == fqw_pkg::op_rdsr ?
                fqw_pkg::st_rdata : is_wrap ? fqw_pkg::st_dummy :
                fqw_pkg::st_addr;
            fqw_pkg::st_addr: nxt_ph = op == fqw_pkg::op_program ?
                fqw_pkg::st_wdata : fqw_pkg::st_mode;
            // Dual read: the mode clocks are its four dummies
            fqw_pkg::st_mode: nxt_ph = is_wrap ? fqw_pkg::st_gap :
                is_quad ? fqw_pkg::st_dummy : fqw_pkg::st_rdata;
            fqw_pkg::st_dummy: nxt_ph = is_wrap ? fqw_pkg::st_mode :
                fqw_pkg::st_rdata;
            default: nxt_ph = fqw_pkg::st_gap;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        sh_next = sh_reg;
        llog_next = llog_reg;
        left_next = left_reg;
        bytes_next = bytes_reg;
        rx_next = rx_reg;
        gap_next = gap_reg;
        rd_valid_next = 1'b0;
        wel_next = wel_reg;
        need_next = need_reg;
        cs_n_next = cs_n_reg;
        refused_next = 1'b0;
        unique case (st_reg)
            fqw_pkg::st_idle: begin
                if (cmd_valid && prog_blocked) begin
                    refused_next = 1'b1;
                end else if (cmd_valid) begin
                    st_next = fqw_pkg::st_cmd;
                    cmd_next = cmd;
                    cs_n_next = 1'b0;
                    sh_next = {start_opc, 24'h0};
                    llog_next = 2'd0;
                    left_next = 6'(fqw_pkg::OPC_BITS);
                end
            end
            fqw_pkg::st_gap: begin
                if (gap_reg == 4'h0) begin
                    st_next = fqw_pkg::st_idle;
                end else begin
                    gap_next = gap_reg - 1'b1;
                end
            end
            fqw_pkg::st_wdata: begin
                if (need_reg && wr_valid) begin
                    need_next = 1'b0;
                    sh_next = {wr_data, 24'h0};
                    left_next = 6'(fqw_pkg::OPC_BITS);
                end else if (phase_end) begin
                    // Only whole bytes end a program frame
                    if (bytes_reg == 8'h0) begin
                        st_next = fqw_pkg::st_gap;
                    end else begin
                        bytes_next = bytes_reg - 1'b1;
                        need_next = 1'b1;
                    end
                end else if (fall_p) begin
                    sh_next = sh_reg << 1;
                    left_next = left_reg - 1'b1;
                end
            end
            fqw_pkg::st_rdata: begin
                if (fall_p) begin
                    rx_next = rx_shift;
                    left_next = left_reg - 1'b1;
                    if (left_reg == 6'd1) begin
                        rd_valid_next = 1'b1;
                        left_next = 6'(fqw_pkg::OPC_BITS >> llog_reg);
                        bytes_next = bytes_reg - 1'b1;
                        if (bytes_reg == 8'h0) begin
                            st_next = fqw_pkg::st_gap;
                        end
                    end
                end
            end
            default: begin
                if (fall_p) begin
                    sh_next = sh_reg << (6'd1 << llog_reg);
                    left_next = left_reg - 1'b1;
                end
                if (phase_end) begin
                    st_next = nxt_ph;
                    llog_next = op_llog;
                    unique case (nxt_ph)
                        fqw_pkg::st_addr: begin
                            sh_next = four_b ? cmd_reg.addr :
                                {cmd_reg.addr[23:0], 8'h0};
                            left_next = addr_clk;
                        end
                        fqw_pkg::st_mode: begin
                            sh_next = {is_wrap ? wrap_byte :
                                fqw_pkg::CONT_MODE_BYTE, 24'h0};
                            left_next = mode_clk;
                        end
                        fqw_pkg::st_dummy: begin
                            sh_next = '1;
                            left_next = dummy_clk;
                        end
                        fqw_pkg::st_wdata: begin
                            // Address, then data on one line
                            // Page alignment is the user's
                            llog_next = 2'd0;
                            bytes_next = cmd_reg.len_m1;
                            need_next = 1'b1;
                        end
                        fqw_pkg::st_rdata: begin
                            sh_next = '1;
                            left_next = 6'(fqw_pkg::OPC_BITS >> op_llog);
                            bytes_next = cmd_reg.len_m1;
                        end
                        default: begin
                            sh_next = '1;
                        end
                    endcase
                end
            end
        endcase
        if (st_next == fqw_pkg::st_gap && st_reg != fqw_pkg::st_gap) begin
            cs_n_next = 1'b1;
            gap_next = 4'(fqw_pkg::CS_HIGH_CYC - 1);
            if (op == fqw_pkg::op_wren) wel_next = 1'b1;
            if (op == fqw_pkg::op_program) wel_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= fqw_pkg::st_idle;
            cmd_reg <= '0;
            sh_reg <= '1;
            llog_reg <= 2'd0;
            left_reg <= 6'd0;
            bytes_reg <= 8'h0;
            rx_reg <= 8'h0;
            gap_reg <= 4'h0;
            rd_valid_reg <= 1'b0;
            wel_reg <= 1'b0;
            need_reg <= 1'b0;
            cs_n_reg <= 1'(fqw_pkg::RESET_CS_N);
            refused_reg <= 1'b0;
            io_out_reg <= 4'hF;
            io_oe_reg <= 4'h0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            sh_reg <= sh_next;
            llog_reg <= llog_next;
            left_reg <= left_next;
            bytes_reg <= bytes_next;
            rx_reg <= rx_next;
            gap_reg <= gap_next;
            rd_valid_reg <= rd_valid_next;
            wel_reg <= wel_next;
            need_reg <= need_next;
            cs_n_reg <= cs_n_next;
            refused_reg <= refused_next;
            io_out_reg <= io_out_next;
            io_oe_reg <= io_oe_next;
        end
    end

    assign cmd_ready = st_reg == fqw_pkg::st_idle;
    assign cmd_refused = refused_reg;
    assign wr_ready = st_reg == fqw_pkg::st_wdata && need_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_data = rx_reg;
    assign busy = st_reg != fqw_pkg::st_idle;
    assign flash = '{cs_n: cs_n_reg, sck: sck, io_out: io_out_reg,
        io_oe: io_oe_reg};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [5:0] ph_rises_reg;
    logic [11:0] frame_rises_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph_rises_reg <= 6'd0;
            frame_rises_reg <= 12'd0;
        end else begin
            ph_rises_reg <= st_next != st_reg ? 6'd0 :
                ph_rises_reg + 6'(rise_p);
            frame_rises_reg <= cs_n_reg ? 12'd0 :
                frame_rises_reg + 12'(rise_p);
        end
    end
    wire leave_addr = st_reg == fqw_pkg::st_addr &&
        st_next != fqw_pkg::st_addr;

    property p_fixed4_addr;
        @(posedge sys_clk) disable iff (rst)
        leave_addr && (op == fqw_pkg::op_dual_read4 ||
            op == fqw_pkg::op_quad_read4) |->
            ph_rises_reg == 6'(fqw_pkg::ADDR_BITS_4B >> op_llog);
    endproperty
    a_fixed4_addr: assert property (p_fixed4_addr)
        else $error("fixed four-byte read sent wrong address length");

    property p_quad_dummy;
        @(posedge sys_clk) disable iff (rst)
        st_reg == fqw_pkg::st_dummy && is_quad &&
            st_next == fqw_pkg::st_rdata |->
            ph_rises_reg == 6'd4 && io_oe_reg == 4'h0;
    endproperty
    a_quad_dummy: assert property (p_quad_dummy)
        else $error("quad read dummy count or release wrong");

    property p_mode_byte;
        @(posedge sys_clk) disable iff (rst)
        $rose(st_reg == fqw_pkg::st_mode) && !is_wrap |->
            sh_reg[31:28] == 4'hF;
    endproperty
    a_mode_byte: assert property (p_mode_byte)
        else $error("continuation mode upper nibble not all ones");

    property p_addr_width;
        @(posedge sys_clk) disable iff (rst)
        leave_addr && four_byte_mode |->
            ph_rises_reg == 6'(fqw_pkg::ADDR_BITS_4B >> op_llog);
    endproperty
    a_addr_width: assert property (p_addr_width)
        else $error("four-byte mode address not 32 bits");

    property p_wrap_seq;
        @(posedge sys_clk) disable iff (rst)
        st_reg == fqw_pkg::st_dummy && is_wrap &&
            st_next == fqw_pkg::st_mode |->
            ph_rises_reg == (four_b ? 6'd8 : 6'd6) ##1
            (st_reg == fqw_pkg::st_mode && io_oe_reg == 4'hF) [*3];
    endproperty
    a_wrap_seq: assert property (p_wrap_seq)
        else $error("wrap setting dummy length or lane drive wrong");

    property p_prog_wel;
        @(posedge sys_clk) disable iff (rst)
        st_reg == fqw_pkg::st_idle && cmd_valid &&
            cmd.op == fqw_pkg::op_program |->
            ##1 (st_reg == fqw_pkg::st_cmd) == $past(wel_reg);
    endproperty
    a_prog_wel: assert property (p_prog_wel)
        else $error("program started without write enable");

    property p_prog_frame;
        @(posedge sys_clk) disable iff (rst)
        $rose(cs_n_reg) && op == fqw_pkg::op_program |->
            frame_rises_reg[2:0] == 3'd0 &&
            frame_rises_reg >= 12'(2 * fqw_pkg::OPC_BITS + addr_clk);
    endproperty
    a_prog_frame: assert property (p_prog_frame)
        else $error("program frame ended off a byte boundary");

    property p_dual_dummy;
        @(posedge sys_clk) disable iff (rst)
        st_reg == fqw_pkg::st_mode && is_dual && phase_end |->
            ph_rises_reg == 6'd4 && st_next == fqw_pkg::st_rdata;
    endproperty
    a_dual_dummy: assert property (p_dual_dummy)
        else $error("dual read dummy clocks not four");

    c_wren: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(wel_reg));
    c_prog: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(wel_reg));
    c_quad_byte: cover property (@(posedge sys_clk) disable iff (rst)
        rd_valid_reg && is_quad);
    c_wrap: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(cs_n_reg) && is_wrap);
endmodule : fqw_host

// >>> hw/fqw_pkg.sv
/*
 * Shared constants and types for the serial flash host controller:
 * opcodes, phase lengths, wrap byte layout, link timing, carriers.
 * Assumes a 200 MHz system clock and one flash device on the link.
 */
package fqw_pkg;

    // ------------------------------------------------------------
    // Opcodes sent on the link
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_WREN = 8'h06;
    localparam logic [7:0] OPC_RDSR = 8'h05;
    localparam logic [7:0] OPC_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_DUAL_READ = 8'hBB;
    localparam logic [7:0] OPC_DUAL_READ4 = 8'hBC;
    localparam logic [7:0] OPC_QUAD_READ = 8'hEB;
    localparam logic [7:0] OPC_QUAD_READ4 = 8'hEC;
    localparam logic [7:0] OPC_SET_WRAP = 8'h77;

    // ------------------------------------------------------------
    // Phase lengths and field positions
    // ------------------------------------------------------------
    localparam int OPC_BITS = 8;
    localparam int ADDR_BITS_3B = 24;
    localparam int ADDR_BITS_4B = 32;
    localparam int MODE_BITS = 8;
    localparam int QUAD_DUMMY_CLK = 4;
    localparam int WRAP_DUMMY_CLK_3B = 6;
    localparam int WRAP_DUMMY_CLK_4B = 8;
    localparam logic [7:0] CONT_MODE_BYTE = 8'hF0;
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LSB = 5;

    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 5;
    localparam int SCK_PERIOD_NS = 40;
    localparam int SCK_HALF_CYC =
        (SCK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
    localparam int SCK_CNT_W = 3;
    localparam int CS_HIGH_NS = 50;
    localparam int CS_HIGH_CYC =
        (CS_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int RESET_CS_N = 1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        op_wren, op_rdsr, op_program, op_dual_read, op_dual_read4,
        op_quad_read, op_quad_read4, op_set_wrap
    } fqw_op_t;

    typedef enum logic [2:0] {
        st_idle, st_cmd, st_addr, st_mode, st_dummy, st_wdata,
        st_rdata, st_gap
    } fqw_state_t;

    typedef struct packed {
        fqw_op_t op;
        logic [31:0] addr;
        logic [7:0] len_m1;
        logic wrap_disable_bit;
        logic [1:0] wrap_length_field;
    } fqw_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } fqw_pins_t;

endpackage : fqw_pkg

// >>> hw/fqw_sync.sv
/*
 * Two-flop synchroniser for a bus of unrelated levels.
 * Assumes each bit is sampled alone; no word coherence is promised.
 */
`timescale 1ns/1ps
module fqw_sync #(
    parameter int W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : fqw_sync

// >>> hw/fqw_sck_gen.sv
/*
 * Serial clock divider with edge pulses aligned to the clock change.
 * Assumes run is only dropped while the serial clock is low; a high
 * phase always completes so that no short pulse reaches the pin.
 */
`timescale 1ns/1ps
module fqw_sck_gen (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    output logic sck,
    output logic rise_p,
    output logic fall_p
);
    logic [fqw_pkg::SCK_CNT_W-1:0] cnt_reg;
    logic [fqw_pkg::SCK_CNT_W-1:0] cnt_next;
    logic sck_reg;
    logic rise_reg;
    logic fall_reg;
    wire active = run || sck_reg;
    wire tog = active &&
        (cnt_reg == fqw_pkg::SCK_CNT_W'(fqw_pkg::SCK_HALF_CYC - 1));

    assign cnt_next = (!active || tog) ? '0 : cnt_reg + 1'b1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            sck_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sck_reg <= sck_reg ^ tog;
            rise_reg <= tog && !sck_reg;
            fall_reg <= tog && sck_reg;
        end
    end

    assign sck = sck_reg;
    assign rise_p = rise_reg;
    assign fall_p = fall_reg;
endmodule : fqw_sck_gen

// >>> sim/fqw_flash_model.sv
/* Behavioural flash device: opcode decode, write enable, status, wrap.
   Assumes SPI mode 0, address mode on four_b, pull-ups on released lines. */
`timescale 1ns/1ps
module fqw_flash_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic four_b,
    input wire logic [3:0] hio,
    input wire logic [3:0] hoe,
    output logic [3:0] io
);
    logic [7:0] opc = 8'h00;
    logic [31:0] adr = 32'h0, ba, m;
    logic write_enable_latch = 1'b0;
    logic wdis = 1'b1;
    logic [1:0] wlen = 2'h0;
    logic [3:0] dq = 4'hF;
    logic doe = 1'b0;
    int n = 0;
    int k;
    logic qe = 1'b1;
    wire quad = qe && (opc == 8'hEB || opc == 8'hEC);
    wire [5:0] al = (four_b || opc == 8'hEC) ? 6'd8 : 6'd6;
    assign io = (hoe & hio) | (~hoe & (doe ? dq : 4'hF));
    always @(posedge sck) begin
        n = n + 1;
        if (n <= 8) opc = {opc[6:0], hio[0]};
        else if (quad && n <= 8 + al) adr = {adr[27:0], hio};
        if (opc == 8'h77 && n == 9 + al) begin
            wdis = hio[0];
            wlen = hio[2:1];
        end
    end
    // Data byte equals the low address byte, so order shows at once
    always @(negedge sck) begin
        k = n - 14 - al;
        m = (32'h8 << wlen) - 32'h1;
        ba = adr + 32'(k / 2);
        if (!wdis) ba = (adr & ~m) | (ba & m);
        if (quad && k >= 0) begin
            doe = 1'b1;
            dq = k[0] ? ba[3:0] : ba[7:4];
        end
        if (opc == 8'h05 && n >= 8) begin
            doe = 1'b1;
            dq = {2'h3, (n % 8 == 6) && write_enable_latch, 1'b1};
        end
    end
    // Program finishes at once, so busy is never seen
    always @(posedge cs_n) begin
        if (opc == 8'h06 && n == 8) write_enable_latch = 1'b1;
        if (opc == 8'h02 && n > 32 && n % 8 == 0) write_enable_latch = 1'b0;
        n = 0;
        doe = 1'b0;
        adr = 32'h0;
        opc = 8'h00;
    end
endmodule : fqw_flash_model

// >>> sim/fqw_host_test.sv
/* Self-checking bench for fqw_host against the flash model.
   Assumes 200 MHz clock; four_byte_mode driven by the bench. */
`timescale 1ns/1ps
module fqw_host_test;
    logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b1;
    logic [7:0] wr_data = 8'hA5, rd_data;
    fqw_pkg::fqw_cmd_t cmd = '0;
    fqw_pkg::fqw_pins_t flash;
    logic cmd_ready, cmd_refused, wr_ready, rd_valid, busy, rf;
    logic [3:0] io_in;
    logic fbm = 1'b0;
    logic [7:0] got [$];
    int error_cnt = 0;
    int n_tests = 0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rd_valid) got.push_back(rd_data);
    fqw_host dut_u (.sys_clk(sys_clk), .rst(rst), .four_byte_mode(fbm),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .cmd_refused(cmd_refused), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .busy(busy), .flash(flash), .io_in(io_in));
    fqw_flash_model dev_u (.sck(flash.sck), .cs_n(flash.cs_n), .four_b(fbm),
        .hio(flash.io_out), .hoe(flash.io_oe), .io(io_in));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic run(input fqw_pkg::fqw_op_t op, input logic [31:0] a,
            input logic [7:0] l, input logic [2:0] w);
        got.delete();
        @(negedge sys_clk);
        cmd = {op, a, l, w};
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        rf = cmd_refused;
        for (int t = 0; t < 4000 && !cmd_ready; t++) @(negedge sys_clk);
        if (!cmd_ready) error_cnt++;
    endtask : run
    task automatic t_four;
        fbm = 1'b1;
        run(fqw_pkg::op_set_wrap, 32'h0, 8'h00, 3'h1);
        run(fqw_pkg::op_quad_read, 32'h0100003E, 8'h03, 3'h0);
        chk(got[0], 8'h3E);
        chk(got[3], 8'h31);
        fbm = 1'b0;
        run(fqw_pkg::op_set_wrap, 32'h0, 8'h00, 3'h4);
        run(fqw_pkg::op_quad_read4, 32'h02000010, 8'h01, 3'h0);
        chk(got[1], 8'h11);
    endtask : t_four
    task automatic t_wel;
        chk({busy, flash.cs_n}, 8'h01);
        run(fqw_pkg::op_program, 32'h100, 8'h00, 3'h0);
        chk(rf, 1'b1);
        run(fqw_pkg::op_wren, 32'h0, 8'h00, 3'h0);
        run(fqw_pkg::op_rdsr, 32'h0, 8'h00, 3'h0);
        chk(got[0], 8'h02);
        run(fqw_pkg::op_program, 32'h1FF, 8'h01, 3'h0);
        chk(rf, 1'b0);
        run(fqw_pkg::op_rdsr, 32'h0, 8'h00, 3'h0);
        chk(got[0], 8'h00);
    endtask : t_wel
    task automatic t_wrap;
        logic [31:0] m;
        logic [7:0] e;
        for (int c = 0; c < 6; c++) begin
            m = (32'h8 << (c - 1)) - 32'h1;
            if (c > 0) run(fqw_pkg::op_set_wrap, 32'h0, 8'h00,
                (c == 5) ? 3'h4 : 3'(c - 1));
            run(fqw_pkg::op_quad_read, 32'h3E, 8'h09, 3'h0);
            chk(8'(got.size()), 8'h0A);
            for (int b = 0; b < 10; b++) begin
                e = 8'h3E + 8'(b);
                if (c % 5 != 0) e = (8'h3E & ~m[7:0]) | (e & m[7:0]);
                chk(got[b], e);
            end
        end
    endtask : t_wrap
    task summarize;
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_wel();
        t_wrap();
        t_four();
        summarize();
    end
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
endmodule : fqw_host_test
